// ---- hdl/dctd_top.sv ----
// Dual counter: byte and word counters with transmit combining and edge demodulation.
// Assumes a synchronous 8-bit register port and capture pins from outside this clock domain.
`timescale 1ns/1ps
module dctd_top (
   input  wire logic                   sys_clk,              // 250 MHz system clock
   input  wire logic                   resetn,               // Asynchronous reset, active low
   input  wire dctd_pkg::dctd_reg_req_t reg_req,             // Register write/read request
   output logic [7:0]                  reg_rdata,            // Read data, one cycle after rd
   input  wire logic                   capture_input_pin_a,  // Capture pin a
   input  wire logic                   capture_input_pin_b,  // Capture pin b
   output logic                        byte_counter_output,  // Byte counter output
   output logic                        word_counter_output,  // Word counter output
   output logic                        combined_output,      // Logic combination of both
   output logic                        capture_irq,          // Capture interrupt pulse
   output logic                        timeout_irq           // Timeout interrupt pulse
);
   import dctd_pkg::*;

   dctd_state_t st_q;
   dctd_state_t st_d;
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   logic        demod;
   logic [1:0]  fn_sel;
   logic [1:0]  sub_sel;
   logic        raw_in;
   logic        rise_ev;
   logic        fall_ev;
   logic        wr_byte_ctl;
   logic        wr_shared;

   function automatic logic [4:0] glitch_len(input logic [1:0] sel);
      case (sel)
         2'h0:    glitch_len = DCTD_GF_W0;
         2'h1:    glitch_len = DCTD_GF_W1;
         2'h2:    glitch_len = DCTD_GF_W2;
         default: glitch_len = DCTD_GF_W3;
      endcase
   endfunction

   function automatic logic combine(input logic [1:0] fn, input logic a, input logic b);
      case (fn)
         DCTD_FN_AND: combine = a & b;
         DCTD_FN_OR:  combine = a | b;
         DCTD_FN_NOR: combine = ~(a | b);
         default:     combine = ~(a & b);
      endcase
   endfunction

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign demod   = st_q.shared[DCTD_SH_MODE];
   assign fn_sel  = st_q.shared[DCTD_SH_FN +: 2];
   assign sub_sel = st_q.shared[DCTD_SH_SUB +: 2];
   // pin choice, second sync stage only
   assign raw_in  = st_q.shared[DCTD_SH_PIN] ? st_q.sync_b[1] : st_q.sync_a[1];
   assign rise_ev = demod && st_q.filt && !st_q.filt_prev &&
                    (fn_sel == DCTD_EDGE_RISE || fn_sel == DCTD_EDGE_BOTH);
   assign fall_ev = demod && !st_q.filt && st_q.filt_prev &&
                    (fn_sel == DCTD_EDGE_FALL || fn_sel == DCTD_EDGE_BOTH);
   assign wr_byte_ctl = reg_req.wr && reg_req.addr == DCTD_A_BYTE_CTL;
   assign wr_shared   = reg_req.wr && reg_req.addr == DCTD_A_SHARED;

   always_comb begin
      st_d = st_q;
      st_d.cap_irq = 1'b0;
      st_d.tout_irq = 1'b0;
      st_d.sync_a = {st_q.sync_a[0], capture_input_pin_a};
      st_d.sync_b = {st_q.sync_b[0], capture_input_pin_b};

      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            DCTD_A_BYTE_CTL: begin
               st_d.byte_ctl = reg_req.wdata;
               if (reg_req.wdata[DCTD_BC_TOUT]) begin
                  st_d.tout_flag = 1'b0;
               end
            end
            DCTD_A_SHARED: begin
               // Flag positions double as write-1-clear in demodulation
               if (demod) begin
                  st_d.shared[7:2] = reg_req.wdata[7:2];
                  if (reg_req.wdata[DCTD_SH_INIT8]) begin
                     st_d.rise_flag = 1'b0;
                  end
                  if (reg_req.wdata[DCTD_SH_INIT16]) begin
                     st_d.fall_flag = 1'b0;
                  end
               end else begin
                  st_d.shared = reg_req.wdata;
               end
            end
            DCTD_A_WORD_CTL:    st_d.word_ctl = reg_req.wdata;
            DCTD_A_COMB:        st_d.comb_hi = reg_req.wdata[7:5];
            DCTD_A_BYTE_RLD:    st_d.byte_rld = reg_req.wdata;
            DCTD_A_WORD_RLD_LO: st_d.word_rld[7:0] = reg_req.wdata;
            DCTD_A_WORD_RLD_HI: st_d.word_rld[15:8] = reg_req.wdata;
            default: begin
            end
         endcase
      end

      // glitch filter ahead of edge detect
      st_d.filt_prev = st_q.filt;
      if (raw_in == st_q.filt) begin
         st_d.gcnt = 5'h00;
      end else if (st_q.gcnt + 5'h01 >= glitch_len(sub_sel)) begin
         st_d.filt = raw_in;
         st_d.gcnt = 5'h00;
      end else begin
         st_d.gcnt = st_q.gcnt + 5'h01;
      end

      st_d.byte_en_prev = st_q.byte_ctl[DCTD_BC_EN];
      st_d.word_en_prev = st_q.word_ctl[DCTD_WC_EN];

      if (demod) begin
         if (!st_q.byte_ctl[DCTD_BC_EN]) begin
            st_d.byte_cnt = DCTD_RELOAD_FF;
         end else if (rise_ev || fall_ev) begin
            // capture into low or high byte
            if (rise_ev) begin
               st_d.cap_lo = st_q.byte_cnt;
            end else begin
               st_d.cap_hi = st_q.byte_cnt;
            end
            // set wins over a clear in the same cycle
            st_d.rise_flag = st_d.rise_flag | rise_ev;
            st_d.fall_flag = st_d.fall_flag | fall_ev;
            st_d.cap_irq = st_q.byte_ctl[DCTD_BC_CAPIE];
            st_d.byte_cnt = DCTD_RELOAD_FF;
         end else if (st_q.byte_cnt == 8'h00) begin
            st_d.tout_flag = 1'b1;
            st_d.tout_irq = st_q.byte_ctl[DCTD_BC_TOIE];
            st_d.byte_cnt = DCTD_RELOAD_FF;
         end else begin
            st_d.byte_cnt = st_q.byte_cnt - 8'h01;
         end
      end else begin
         if (sub_sel != DCTD_SUB_ALT) begin
            st_d.alt_word = 1'b0;
         end
         if (!st_q.byte_ctl[DCTD_BC_EN]) begin
            st_d.byte_out = ~st_q.shared[DCTD_SH_INIT8];
            st_d.byte_cnt = st_q.byte_rld;
         end else if (!st_q.byte_en_prev) begin
            st_d.byte_out = st_q.shared[DCTD_SH_INIT8];
            st_d.byte_cnt = st_q.byte_rld;
         end else if (!(sub_sel == DCTD_SUB_ALT && st_q.alt_word)) begin
            if (st_q.byte_cnt == 8'h00) begin
               st_d.byte_out = ~st_q.byte_out;
               st_d.byte_cnt = st_q.byte_rld;
               if (sub_sel == DCTD_SUB_ALT) begin
                  st_d.alt_word = 1'b1;
                  st_d.word_cnt = st_q.word_rld;
               end
            end else begin
               st_d.byte_cnt = st_q.byte_cnt - 8'h01;
            end
         end
         if (sub_sel == DCTD_SUB_FORCE0) begin
            st_d.word_out = 1'b0;
         end else if (sub_sel == DCTD_SUB_FORCE1) begin
            st_d.word_out = 1'b1;
         end else if (!st_q.word_ctl[DCTD_WC_EN]) begin
            st_d.word_out = ~st_q.shared[DCTD_SH_INIT16];
            st_d.word_cnt = st_q.word_rld;
         end else if (!st_q.word_en_prev) begin
            st_d.word_out = st_q.shared[DCTD_SH_INIT16];
            st_d.word_cnt = st_q.word_rld;
         end else if (!(sub_sel == DCTD_SUB_ALT && !st_q.alt_word)) begin
            if (st_q.word_cnt == DCTD_RST_WORD) begin
               st_d.word_out = ~st_q.word_out;
               st_d.word_cnt = st_q.word_rld;
               if (sub_sel == DCTD_SUB_ALT) begin
                  st_d.alt_word = 1'b0;
                  st_d.byte_cnt = st_q.byte_rld;
               end
            end else begin
               st_d.word_cnt = st_q.word_cnt - 16'h0001;
            end
         end
      end

      // output combining, one cycle behind the counter outputs
      st_d.comb_out = combine(fn_sel, st_q.byte_out, st_q.word_out);

      // Reads: registered, one cycle latency
      st_d.rdata = DCTD_RD_UNMAPPED;
      if (reg_req.rd) begin
         case (reg_req.addr)
            DCTD_A_BYTE_CTL: begin
               st_d.rdata = st_q.byte_ctl;
               st_d.rdata[DCTD_BC_TOUT] = st_q.tout_flag;
            end
            DCTD_A_SHARED: begin
               st_d.rdata = demod ? {st_q.shared[7:2], st_q.rise_flag, st_q.fall_flag} : st_q.shared;
            end
            DCTD_A_WORD_CTL:    st_d.rdata = st_q.word_ctl;
            DCTD_A_COMB:        st_d.rdata = {st_q.comb_out, st_q.comb_hi[1:0], DCTD_COMB_RSV};
            DCTD_A_BYTE_RLD:    st_d.rdata = st_q.byte_rld;
            DCTD_A_WORD_RLD_LO: st_d.rdata = st_q.word_rld[7:0];
            DCTD_A_WORD_RLD_HI: st_d.rdata = st_q.word_rld[15:8];
            DCTD_A_CAP_LO:      st_d.rdata = st_q.cap_lo;
            DCTD_A_CAP_HI:      st_d.rdata = st_q.cap_hi;
            default:            st_d.rdata = DCTD_RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata           = st_q.rdata;
   assign byte_counter_output = st_q.byte_out;
   assign word_counter_output = st_q.word_out;
   assign combined_output     = st_q.comb_out;
   assign capture_irq         = st_q.cap_irq;
   assign timeout_irq         = st_q.tout_irq;

   default clocking dctd_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_combine_fn: assert property (!$past(demod) |-> combined_output == combine($past(fn_sel),
      $past(st_q.byte_out), $past(st_q.word_out)))
      else $error("combined output wrong");
   a_word_force: assert property (!demod && sub_sel == DCTD_SUB_FORCE0 ##1 !demod
      |-> !word_counter_output)
      else $error("word output not forced low");
   a_glitch_width: assert property (demod && st_q.filt != st_q.filt_prev |->
      $past(raw_in) == st_q.filt)
      else $error("filter changed without input");
   a_glitch_four: assert property (st_q.filt != st_q.filt_prev && glitch_len($past(sub_sel)) == DCTD_GF_W1
      |-> $past(raw_in, 2) == st_q.filt && $past(raw_in, 3) == st_q.filt && $past(raw_in, 4) == st_q.filt)
      else $error("short pulse passed filter");
   a_byte_idle: assert property (!demod && !st_q.byte_ctl[DCTD_BC_EN] ##1
      !demod && !st_q.byte_ctl[DCTD_BC_EN] && !wr_shared
      |=> byte_counter_output == ~$past(st_q.shared[DCTD_SH_INIT8]))
      else $error("idle byte output wrong");
   a_byte_start: assert property (!demod && st_q.byte_ctl[DCTD_BC_EN] && !st_q.byte_en_prev
      |=> byte_counter_output == $past(st_q.shared[DCTD_SH_INIT8]))
      else $error("byte start level wrong");
   a_word_start: assert property (!demod && st_q.word_ctl[DCTD_WC_EN] && !st_q.word_en_prev
      && (sub_sel == DCTD_SUB_NORMAL || sub_sel == DCTD_SUB_ALT)
      |=> word_counter_output == $past(st_q.shared[DCTD_SH_INIT16]))
      else $error("word start level wrong");
   a_alt_end: assert property (!demod && sub_sel == DCTD_SUB_NORMAL |=> !st_q.alt_word)
      else $error("alternating not ended");
   a_rise_flag: assert property (rise_ev && st_q.byte_ctl[DCTD_BC_EN] |=> st_q.rise_flag)
      else $error("rising flag not set");
   a_fall_flag: assert property (fall_ev && st_q.byte_ctl[DCTD_BC_EN] |=> st_q.fall_flag)
      else $error("falling flag not set");
   a_capture_low: assert property (rise_ev && st_q.byte_ctl[DCTD_BC_EN] |=>
      st_q.cap_lo == $past(st_q.byte_cnt) && st_q.byte_cnt == DCTD_RELOAD_FF)
      else $error("capture or reload wrong");
   a_capture_high: assert property (fall_ev && st_q.byte_ctl[DCTD_BC_EN] |=>
      st_q.cap_hi == $past(st_q.byte_cnt) && st_q.byte_cnt == DCTD_RELOAD_FF)
      else $error("high capture or reload wrong");
   a_capture_irq: assert property ((rise_ev || fall_ev) && st_q.byte_ctl[DCTD_BC_EN]
      |=> capture_irq == $past(st_q.byte_ctl[DCTD_BC_CAPIE]) ##1 !capture_irq)
      else $error("capture request wrong");
   a_timeout_wrap: assert property (demod && st_q.byte_ctl[DCTD_BC_EN] && st_q.byte_cnt == 8'h00
      && !rise_ev && !fall_ev |=> st_q.tout_flag && st_q.byte_cnt == DCTD_RELOAD_FF)
      else $error("timeout wrap wrong");
   a_flag_sticky: assert property (st_q.tout_flag && !(wr_byte_ctl && reg_req.wdata[DCTD_BC_TOUT])
      |=> st_q.tout_flag)
      else $error("timeout flag lost");
endmodule

// ---- shared/dctd_pkg.sv ----
// Constants and types for the dual counter with transmit and demodulation modes.
// Assumes an 8-bit register port on the system clock and asynchronous capture pins.
package dctd_pkg;

   // Register addresses on the 4-bit register port
   localparam logic [3:0] DCTD_A_BYTE_CTL = 4'h0, DCTD_A_SHARED = 4'h1, DCTD_A_WORD_CTL = 4'h2,
                          DCTD_A_COMB = 4'h3, DCTD_A_BYTE_RLD = 4'h4, DCTD_A_WORD_RLD_LO = 4'h5,
                          DCTD_A_WORD_RLD_HI = 4'h6, DCTD_A_CAP_LO = 4'h7, DCTD_A_CAP_HI = 4'h8;

   // Field positions
   localparam int DCTD_BC_EN = 7, DCTD_BC_TOUT = 5, DCTD_BC_CAPIE = 2, DCTD_BC_TOIE = 1;
   localparam int DCTD_SH_MODE = 7, DCTD_SH_PIN = 6, DCTD_SH_FN = 4, DCTD_SH_SUB = 2;
   localparam int DCTD_SH_INIT8 = 1, DCTD_SH_INIT16 = 0, DCTD_WC_EN = 7, DCTD_CB_STAT = 7;

   // Field encodings
   localparam logic [1:0] DCTD_FN_AND = 2'h0, DCTD_FN_OR = 2'h1, DCTD_FN_NOR = 2'h2, DCTD_FN_NAND = 2'h3;
   localparam logic [1:0] DCTD_SUB_NORMAL = 2'h0, DCTD_SUB_ALT = 2'h1, DCTD_SUB_FORCE0 = 2'h2,
                          DCTD_SUB_FORCE1 = 2'h3;
   localparam logic [1:0] DCTD_EDGE_NONE = 2'h0, DCTD_EDGE_RISE = 2'h1, DCTD_EDGE_FALL = 2'h2,
                          DCTD_EDGE_BOTH = 2'h3;

   // Reset and fixed values
   localparam logic [7:0] DCTD_RST_BYTE = 8'h00, DCTD_RELOAD_FF = 8'hff, DCTD_RD_UNMAPPED = 8'h00;
   localparam logic [15:0] DCTD_RST_WORD = 16'h0000;
   localparam logic [4:0] DCTD_COMB_RSV = 5'h1f;

   // Glitch filter widths in system clock cycles
   localparam logic [4:0] DCTD_GF_W0 = 5'h01, DCTD_GF_W1 = 5'h04, DCTD_GF_W2 = 5'h08, DCTD_GF_W3 = 5'h10;

   typedef struct packed {
      logic       wr;    // Write strobe
      logic       rd;    // Read strobe
      logic [3:0] addr;  // Register address
      logic [7:0] wdata; // Write data
   } dctd_reg_req_t;

   typedef struct packed {
      logic [7:0]  byte_ctl;
      logic [7:0]  shared;
      logic [7:0]  word_ctl;
      logic [2:0]  comb_hi;
      logic [7:0]  byte_rld;
      logic [15:0] word_rld;
      logic        rise_flag;
      logic        fall_flag;
      logic        tout_flag;
      logic [7:0]  byte_cnt;
      logic [15:0] word_cnt;
      logic        byte_out;
      logic        word_out;
      logic        comb_out;
      logic        byte_en_prev;
      logic        word_en_prev;
      logic        alt_word;
      logic [1:0]  sync_a;
      logic [1:0]  sync_b;
      logic        filt;
      logic        filt_prev;
      logic [4:0]  gcnt;
      logic [7:0]  cap_lo;
      logic [7:0]  cap_hi;
      logic        cap_irq;
      logic        tout_irq;
      logic [7:0]  rdata;
   } dctd_state_t;

endpackage

// ---- verification/dctd_sig_model.sv ----
// Model of the modulated signal lines that feed the two capture pins.
// Assumes the bench clock; line edges fall on falling clock edges.
`timescale 1ns/1ps
module dctd_sig_model (
   input  wire logic sys_clk, // System clock
   output logic      pin_a,   // Line to capture pin a
   output logic      pin_b    // Line to capture pin b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // High for hi cycles, then low for lo cycles, on one line
   task automatic pulse(input logic sel, input int hi, input int lo);
      @(negedge sys_clk);
      if (sel) pin_b = 1'b1;
      else pin_a = 1'b1;
      repeat (hi) @(negedge sys_clk);
      if (sel) pin_b = 1'b0;
      else pin_a = 1'b0;
      repeat (lo) @(negedge sys_clk);
   endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the dual counter block.
// Assumes the signal line model drives the capture pins.
`timescale 1ns/1ps
module tb;
   import dctd_pkg::*;
   logic          sys_clk = 1'b0;
   logic          resetn = 1'b0;
   dctd_reg_req_t reg_req = '0;
   logic [7:0]    reg_rdata, d;
   logic          pin_a, pin_b, bout, wout, cout, cirq, tirq;
   int            fail_count = 0, n_tests = 0, cyc = 0, ncap = 0, t_cap = 0, t_to = 0;

   always #2 sys_clk = ~sys_clk;

   dctd_top i_dctd_top (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .capture_input_pin_a(pin_a), .capture_input_pin_b(pin_b), .byte_counter_output(bout),
      .word_counter_output(wout), .combined_output(cout), .capture_irq(cirq), .timeout_irq(tirq));
   dctd_sig_model i_dctd_sig_model (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

   // Hang guard far above the roughly one thousand cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cirq === 1'b1) begin
         ncap <= ncap + 1;
         t_cap <= cyc;
      end
      if (tirq === 1'b1) t_to <= cyc;
      if (cyc == 20000) begin
         fail_count++;
         $display("[ERR] %0t run did not finish", $time);
         test_done();
      end
   end

   task automatic test_done;
      $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge sys_clk);
      reg_req.wr = 1'b0;
   endtask

   // Read data stands for the cycle after the taking edge only
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(negedge sys_clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      reg_req.rd = 1'b0;
      v = reg_rdata;
   endtask

   // Cycle at which the chosen output next changes
   task automatic tog(input logic w, output int t);
      logic v;
      int   k;
      v = w ? wout : bout;
      for (k = 0; k < 300 && (w ? wout : bout) === v; k++) @(negedge sys_clk);
      t = cyc;
   endtask

   task automatic t_reset;
      rd(DCTD_A_BYTE_CTL, d);
      chk(d, 8'h00, "byte ctl reset");
      rd(DCTD_A_SHARED, d);
      chk(d, 8'h00, "shared reset");
      rd(DCTD_A_WORD_CTL, d);
      chk(d, 8'h00, "word ctl reset");
      rd(DCTD_A_COMB, d);
      chk(d, 8'h9f, "comb reset");
      rd(4'h9, d);
      chk(d, 8'h00, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_xmit;
      int t1, t2;
      wr(DCTD_A_SHARED, 8'h03);
      repeat (2) @(negedge sys_clk);
      chk({6'h00, bout, wout}, 8'h00, "idle levels");
      wr(DCTD_A_BYTE_RLD, 8'h09);
      wr(DCTD_A_WORD_RLD_LO, 8'h04);
      wr(DCTD_A_WORD_RLD_HI, 8'h00);
      // each output shows its inverted initial bit while its own counter is off and loads the initial bit when that counter starts
      wr(DCTD_A_BYTE_CTL, 8'h80);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, bout}, 8'h01, "byte start level");
      tog(1'b0, t1);
      tog(1'b0, t2);
      chk({7'h00, t2 - t1 == 10}, 8'h01, "byte half period");
      wr(DCTD_A_WORD_CTL, 8'h80);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, wout}, 8'h01, "word start level");
      tog(1'b1, t1);
      tog(1'b1, t2);
      chk({7'h00, t2 - t1 == 5}, 8'h01, "word half period");
      wr(DCTD_A_BYTE_CTL, 8'h00);
      wr(DCTD_A_WORD_CTL, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk({6'h00, bout, wout}, 8'h00, "stopped levels");
      $display("test transmit done");
   endtask

   task automatic t_logic;
      logic b, w, e;
      for (int f = 0; f < 4; f++) begin
         for (int i = 0; i < 4; i++) begin
            wr(DCTD_A_SHARED, {2'b00, 2'(f), 2'b00, 2'(i)});
            repeat (3) @(negedge sys_clk);
            b = ~i[1];
            w = ~i[0];
            e = (f == 0) ? (b & w) : (f == 1) ? (b | w) : (f == 2) ? ~(b | w) : ~(b & w);
            chk({7'h00, cout}, {7'h00, e}, "combined pin");
            rd(DCTD_A_COMB, d);
            chk(d, {e, 7'h1f}, "combined reg");
         end
      end
      $display("test logic done");
   endtask

   task automatic t_force;
      wr(DCTD_A_SHARED, 8'h08);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, wout}, 8'h00, "forced low");
      wr(DCTD_A_SHARED, 8'h0d);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, wout}, 8'h01, "forced high");
      wr(DCTD_A_SHARED, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, wout}, 8'h00, "normal again");
      $display("test force done");
   endtask

   // Byte and word counters hand over to each other, then run apart again
   task automatic t_alt;
      int t1, t2, t3;
      wr(DCTD_A_SHARED, 8'h07);
      wr(DCTD_A_BYTE_CTL, 8'h80);
      wr(DCTD_A_WORD_CTL, 8'h80);
      repeat (2) @(negedge sys_clk);
      tog(1'b0, t1);
      tog(1'b1, t2);
      tog(1'b0, t3);
      chk({7'h00, t2 - t1 == 5}, 8'h01, "alternate hand-over");
      chk({7'h00, t3 - t1 == 15}, 8'h01, "alternate period");
      wr(DCTD_A_SHARED, 8'h03);
      tog(1'b0, t1);
      tog(1'b0, t2);
      chk({7'h00, t2 - t1 == 10}, 8'h01, "normal after alternate");
      wr(DCTD_A_BYTE_CTL, 8'h00);
      wr(DCTD_A_WORD_CTL, 8'h00);
      $display("test alternate done");
   endtask

   task automatic t_capture;
      int n0, t1;
      wr(DCTD_A_BYTE_CTL, 8'h84);
      wr(DCTD_A_SHARED, 8'h90);
      n0 = ncap;
      i_dctd_sig_model.pulse(1'b0, 20, 19);
      t1 = t_cap;
      i_dctd_sig_model.pulse(1'b0, 20, 19);
      chk(8'(ncap - n0), 8'h02, "capture irqs");
      chk({7'h00, t_cap - t1 == 40}, 8'h01, "capture spacing");
      rd(DCTD_A_CAP_LO, d);
      chk(d, 8'hd8, "low capture");
      rd(DCTD_A_SHARED, d);
      chk(d, 8'h92, "rise only");
      wr(DCTD_A_SHARED, 8'hb0);
      i_dctd_sig_model.pulse(1'b0, 20, 19);
      rd(DCTD_A_CAP_HI, d);
      chk(d, 8'hec, "high capture");
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hb3, "both flags");
      wr(DCTD_A_SHARED, 8'hb2);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hb1, "rise cleared");
      wr(DCTD_A_BYTE_CTL, 8'h80);
      n0 = ncap;
      i_dctd_sig_model.pulse(1'b0, 10, 10);
      chk(8'(ncap - n0), 8'h00, "irq gated");
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hb3, "flags without irq");
      wr(DCTD_A_SHARED, 8'hb3);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hb0, "both cleared");
      $display("test capture done");
   endtask

   task automatic t_pin_glitch;
      wr(DCTD_A_SHARED, 8'hd0);
      i_dctd_sig_model.pulse(1'b0, 10, 10);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hd0, "other pin ignored");
      i_dctd_sig_model.pulse(1'b1, 10, 10);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'hd2, "pin b seen");
      wr(DCTD_A_SHARED, 8'h96);
      i_dctd_sig_model.pulse(1'b0, 2, 10);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'h94, "glitch dropped");
      i_dctd_sig_model.pulse(1'b0, 8, 10);
      rd(DCTD_A_SHARED, d);
      chk(d, 8'h96, "wide pulse kept");
      $display("test pin and glitch done");
   endtask

   task automatic t_timeout;
      int t0, k;
      wr(DCTD_A_BYTE_CTL, 8'h82);
      t0 = t_to;
      for (k = 0; k < 300 && t_to == t0; k++) @(negedge sys_clk);
      t0 = t_to;
      for (k = 0; k < 300 && t_to == t0; k++) @(negedge sys_clk);
      chk({7'h00, t_to - t0 == 256}, 8'h01, "timeout period");
      rd(DCTD_A_BYTE_CTL, d);
      chk(d, 8'ha2, "timeout flag");
      wr(DCTD_A_BYTE_CTL, 8'ha2);
      rd(DCTD_A_BYTE_CTL, d);
      chk(d, 8'h82, "timeout cleared");
      $display("test timeout done");
   endtask

   initial begin
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_xmit();
      t_logic();
      t_force();
      t_alt();
      t_capture();
      t_pin_glitch();
      t_timeout();
      test_done();
   end
endmodule
